// ==== hdl/lsc_pkg.sv ====
package lsc_pkg;

    // Clock and timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_PS = 25_000;
    localparam int LINK_FAIL_MS = 50;
    localparam int LINK_FAIL_CYC = LINK_FAIL_MS * (CLK_HZ / 1000);
    localparam int BIT_TIME_PS = 100_000;
    localparam int CRS_MIN_PS = BIT_TIME_PS * 13 / 10;
    localparam int CRS_MAX_PS = BIT_TIME_PS * 23 / 10;
    localparam int CRS_MIN_CYC = (CRS_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CRS_MAX_CYC = CRS_MAX_PS / CLK_PERIOD_PS;
    localparam int CRS_HOLD_CYC = CRS_MIN_CYC;
    localparam logic [1:0] STRAP_DELAY = 2'h3;

    // Register indices; the byte address is four times the index
    localparam int AW = 12;
    localparam logic [9:0] IDX_SELF_CTL = 10'h114;
    localparam logic [9:0] IDX_LINE_ST = 10'h134;
    localparam logic [9:0] IDX_SELF_ST = 10'h136;

    // Identifier fields in bits 5..0
    localparam logic [5:0] LINE_ID = 6'h14;
    localparam logic [5:0] CTL_ID = 6'h15;
    localparam logic [5:0] SELF_ID = 6'h16;

    // Line status fields
    localparam int LS_LINK = 7;
    localparam int LS_AUI = 8;
    localparam int LS_TP = 9;
    localparam int LS_POL = 12;
    localparam int LS_CRS = 14;

    // Self control fields
    localparam int CTL_RESET = 6;
    localparam int CTL_SUSPEND = 8;
    localparam int CTL_SLEEP_EN = 9;
    localparam int CTL_STANDBY = 10;
    localparam int CTL_SEL0 = 12;
    localparam int CTL_SEL1 = 13;
    localparam int CTL_VAL0 = 14;
    localparam int CTL_VAL1 = 15;
    localparam logic [15:0] CTL_RESET_VAL = 16'h0015;
    localparam logic [15:0] CTL_WRITABLE = 16'hF700;

    // Self status fields
    localparam int ST_3V3 = 6;
    localparam int ST_INIT = 7;
    localparam int ST_BUSY = 8;
    localparam int ST_PRESENT = 9;
    localparam int ST_VALID = 10;
    localparam int ST_EXT = 11;
    localparam int ST_SIZE = 12;

    typedef enum logic [1:0] {
        PWR_AWAKE = 2'b00,
        PWR_SW_SUSPEND = 2'b01,
        PWR_HW_STANDBY = 2'b10,
        PWR_HW_SUSPEND = 2'b11
    } lsc_pwr_type;

    // Asynchronous pins, all synchronised before use
    typedef struct packed {
        logic tp_activity;
        logic rx_polarity_ok;
        logic rx_data;
        logic sleep;
        logic mem_data_in;
        logic ext_decode;
        logic supply_3v3;
    } lsc_pins_type;

    // Serial memory engine status, same clock
    typedef struct packed {
        logic init_done;
        logic mem_select;
        logic checksum_ok;
        logic size64;
        logic load_valid;
        logic [15:0] load_data;
    } lsc_mem_status_type;

endpackage

// ==== hdl/lsc_link_timer.sv ====
`timescale 1ns/1ps
module lsc_link_timer #(
    parameter int FAIL_CYC = lsc_pkg::LINK_FAIL_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Receiver activity
    input wire logic i_activity,
    // Status
    output logic o_link_good
);
    import lsc_pkg::*;

    localparam int CW = $clog2(FAIL_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(FAIL_CYC - 1);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic good_ff;
    logic nxt_good;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_good = good_ff;
        if (i_activity) begin
            nxt_cnt = '0;
            nxt_good = 1'b1;
        end else if (good_ff) begin
            if (cnt_ff == LAST) begin
                nxt_good = 1'b0;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cnt_ff <= '0;
            good_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            good_ff <= nxt_good;
        end
    end

    assign o_link_good = good_ff;
endmodule

// ==== hdl/lsc_carrier_sense.sv ====
`timescale 1ns/1ps
module lsc_carrier_sense #(
    parameter int HOLD_CYC = lsc_pkg::CRS_HOLD_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Recovered receive data, already synchronised
    input wire logic i_data,
    // Status
    output logic o_carrier
);
    import lsc_pkg::*;

    localparam int CW = $clog2(HOLD_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HOLD_CYC - 1);

    logic prev_ff;
    logic crs_ff;
    logic [CW-1:0] cnt_ff;
    logic nxt_crs;
    logic [CW-1:0] nxt_cnt;

    // Every rising edge restarts the hold; carrier drops a fixed time after the last one
    always_comb begin
        nxt_crs = crs_ff;
        nxt_cnt = cnt_ff;
        if (i_data && !prev_ff) begin
            nxt_crs = 1'b1;
            nxt_cnt = '0;
        end else if (crs_ff) begin
            if (cnt_ff == LAST) begin
                nxt_crs = 1'b0;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            prev_ff <= 1'b0;
            crs_ff <= 1'b0;
            cnt_ff <= '0;
        end else begin
            prev_ff <= i_data;
            crs_ff <= nxt_crs;
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_carrier = crs_ff;
endmodule

// ==== hdl/lsc_status_regs.sv ====
// Summary of operation
// - Line status bits 5..0 read 010100
// - Polarity bit shows true polarity; auto-correct
// - Carrier sense holds 1.3-2.3 bits after rise
// - Bits 8/9 show attachment or twisted pair
// - Self control bits 5..0 hold 010101
// - Writing reset bit starts chip reset once
// - Suspend bit partially resets, halts traffic
// - In-range I/O write leaves software suspend
// - Sleep enable honours sleep pin, else ignored
// - Standby select picks standby or suspend
// - Select 0 picks link LED or value
// - Select 1 picks bus activity or value
// - Value bit set drives pin low
// - Control resets to 0x0015, memory may load
// - Self status bits 5..0 read 010110
// - Init done set after initialization finishes
// - Serial busy mirrors memory select; host waits
// - Memory present samples data pin once after reset
// - Memory valid reports checksum correct
// - External decode presence status bit
// - Size bit meaningful only present and valid
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module lsc_status_regs
    import lsc_pkg::*;
#(
    parameter int LINK_FAIL_CYCLES = lsc_pkg::LINK_FAIL_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Avalon-MM slave
    input wire logic [lsc_pkg::AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Device pins
    input wire lsc_pkg::lsc_pins_type i_pins,
    // Core side
    input wire logic i_polarity_fix_disable,
    input wire logic i_tp_in_use,
    input wire logic i_rx_bus_activity,
    input wire logic i_io_write_in_range,
    input wire lsc_pkg::lsc_mem_status_type i_mem,
    // Outputs
    output logic o_rx_invert,
    output logic o_general_output_0,
    output logic o_general_output_1,
    output logic o_chip_reset,
    output logic o_partial_reset,
    output logic o_txrx_halt,
    output logic o_hw_standby,
    output logic o_hw_suspend
);
    import lsc_pkg::*;

    localparam int PW = $bits(lsc_pins_type);
    lsc_pins_type sync1_ff;
    lsc_pins_type pin_s;
    logic chip_rst_ff;
    logic nrst_int;
    logic nrst_core;

    // Synchronisers, one pair per pin
    generate
        for (genvar b = 0; b < PW; b++) begin : g_sync
            always_ff @(posedge i_clk) begin
                if (!i_nrst) begin
                    sync1_ff[b] <= 1'b0;
                    pin_s[b] <= 1'b0;
                end else begin
                    sync1_ff[b] <= i_pins[b];
                    pin_s[b] <= sync1_ff[b];
                end
            end
        end
    endgenerate
    assign nrst_int = i_nrst && !chip_rst_ff;
    // Bus handshake: one wait cycle, then the request completes
    logic ack_ff;
    logic nxt_ack;
    logic req;
    logic accept;
    logic [9:0] idx;
    logic hit_ctl;
    logic hit_line;
    logic hit_self;

    assign req = i_avs_read || i_avs_write;
    assign accept = req && ack_ff;
    assign o_avs_waitrequest = req && !ack_ff;
    assign idx = i_avs_address[AW-1:2];
    assign hit_ctl = (i_avs_address[1:0] == 2'h0) && (idx == IDX_SELF_CTL);
    assign hit_line = (i_avs_address[1:0] == 2'h0) && (idx == IDX_LINE_ST);
    assign hit_self = (i_avs_address[1:0] == 2'h0) && (idx == IDX_SELF_ST);

    always_comb begin
        nxt_ack = req && !ack_ff;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
        end
    end

    // Self control register and chip reset
    logic [15:0] ctl_ff;
    logic [15:0] nxt_ctl;
    logic nxt_chip_rst;
    logic wr_ctl;

    assign wr_ctl = accept && i_avs_write && hit_ctl;

    always_comb begin
        nxt_ctl = ctl_ff;
        nxt_chip_rst = 1'b0;
        if (i_mem.load_valid) begin
            nxt_ctl = (i_mem.load_data & CTL_WRITABLE) | CTL_RESET_VAL;
        end
        if (i_io_write_in_range) begin
            nxt_ctl[CTL_SUSPEND] = 1'b0;
        end
        // A host write lands after the wake clear, so setting suspend is not undone
        if (wr_ctl) begin
            if (i_avs_byteenable[1]) begin
                nxt_ctl[15:8] = i_avs_writedata[15:8] & CTL_WRITABLE[15:8];
            end
            if (i_avs_byteenable[0] && i_avs_writedata[CTL_RESET]) begin
                nxt_chip_rst = 1'b1;
            end
        end
        nxt_ctl[5:0] = CTL_ID;
        nxt_ctl[CTL_RESET] = 1'b0;
    end

    always_ff @(posedge i_clk) begin
        if (!nrst_int) begin
            ctl_ff <= CTL_RESET_VAL;
            chip_rst_ff <= 1'b0;
        end else begin
            ctl_ff <= nxt_ctl;
            chip_rst_ff <= nxt_chip_rst;
        end
    end

    // Power mode
    lsc_pwr_type pwr_ff;
    lsc_pwr_type nxt_pwr;
    logic part_rst_ff;
    logic nxt_part_rst;

    always_comb begin
        if (ctl_ff[CTL_SUSPEND]) begin
            nxt_pwr = PWR_SW_SUSPEND;
        end else if (ctl_ff[CTL_SLEEP_EN] && !pin_s.sleep) begin
            nxt_pwr = ctl_ff[CTL_STANDBY] ? PWR_HW_STANDBY : PWR_HW_SUSPEND;
        end else begin
            nxt_pwr = PWR_AWAKE;
        end
        nxt_part_rst = (nxt_pwr == PWR_SW_SUSPEND) && (pwr_ff != PWR_SW_SUSPEND);
    end

    always_ff @(posedge i_clk) begin
        if (!nrst_int) begin
            pwr_ff <= PWR_AWAKE;
            part_rst_ff <= 1'b0;
        end else begin
            pwr_ff <= nxt_pwr;
            part_rst_ff <= nxt_part_rst;
        end
    end

    assign o_chip_reset = chip_rst_ff;
    assign o_partial_reset = part_rst_ff;
    assign o_txrx_halt = (pwr_ff != PWR_AWAKE);
    assign o_hw_standby = (pwr_ff == PWR_HW_STANDBY);
    assign o_hw_suspend = (pwr_ff == PWR_HW_SUSPEND);

    // Line monitors are cleared with the rest of the core while in software suspend
    assign nrst_core = nrst_int && (pwr_ff != PWR_SW_SUSPEND);

    logic link_good;
    logic carrier;

    lsc_link_timer #(
        .FAIL_CYC(LINK_FAIL_CYCLES)
    ) u_link (
        .i_clk(i_clk),
        .i_nrst(nrst_core),
        .i_activity(pin_s.tp_activity),
        .o_link_good(link_good)
    );

    lsc_carrier_sense #(
        .HOLD_CYC(CRS_HOLD_CYC)
    ) u_crs (
        .i_clk(i_clk),
        .i_nrst(nrst_core),
        .i_data(pin_s.rx_data),
        .o_carrier(carrier)
    );

    // Pin outputs and polarity correction
    logic gen0_ff;
    logic gen1_ff;
    logic inv_ff;
    logic nxt_gen0;
    logic nxt_gen1;
    logic nxt_inv;

    always_comb begin
        // LED pins are active low, so a good link pulls the pin low
        nxt_gen0 = ctl_ff[CTL_SEL0] ? !ctl_ff[CTL_VAL0] : !link_good;
        nxt_gen1 = ctl_ff[CTL_SEL1] ? !ctl_ff[CTL_VAL1] : !i_rx_bus_activity;
        nxt_inv = !pin_s.rx_polarity_ok && !i_polarity_fix_disable;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            gen0_ff <= 1'b1;
            gen1_ff <= 1'b1;
            inv_ff <= 1'b0;
        end else begin
            gen0_ff <= nxt_gen0;
            gen1_ff <= nxt_gen1;
            inv_ff <= nxt_inv;
        end
    end

    assign o_general_output_0 = gen0_ff;
    assign o_general_output_1 = gen1_ff;
    assign o_rx_invert = inv_ff;

    // Memory presence strap, taken once the synchroniser holds a real sample
    logic [1:0] strap_cnt_ff;
    logic [1:0] nxt_strap_cnt;
    logic present_ff;
    logic nxt_present;

    always_comb begin
        nxt_strap_cnt = strap_cnt_ff;
        nxt_present = present_ff;
        if (strap_cnt_ff != STRAP_DELAY) begin
            nxt_strap_cnt = strap_cnt_ff + 2'h1;
            if (nxt_strap_cnt == STRAP_DELAY) begin
                nxt_present = pin_s.mem_data_in;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!nrst_int) begin
            strap_cnt_ff <= 2'h0;
            present_ff <= 1'b0;
        end else begin
            strap_cnt_ff <= nxt_strap_cnt;
            present_ff <= nxt_present;
        end
    end

    // Status words
    logic [15:0] line_word;
    logic [15:0] self_word;

    always_comb begin
        line_word = 16'h0000;
        line_word[5:0] = LINE_ID;
        line_word[LS_LINK] = link_good;
        line_word[LS_AUI] = !i_tp_in_use;
        line_word[LS_TP] = i_tp_in_use;
        line_word[LS_POL] = pin_s.rx_polarity_ok;
        line_word[LS_CRS] = carrier;
        self_word = 16'h0000;
        self_word[5:0] = SELF_ID;
        self_word[ST_3V3] = pin_s.supply_3v3;
        self_word[ST_INIT] = i_mem.init_done && (strap_cnt_ff == STRAP_DELAY);
        self_word[ST_BUSY] = i_mem.mem_select;
        self_word[ST_PRESENT] = present_ff;
        self_word[ST_VALID] = i_mem.checksum_ok;
        self_word[ST_EXT] = pin_s.ext_decode;
        self_word[ST_SIZE] = present_ff && i_mem.checksum_ok && i_mem.size64;
    end

    // Read data, captured in the wait cycle and held through completion
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    always_comb begin
        nxt_rdata = rdata_ff;
        if (i_avs_read && !ack_ff) begin
            if (hit_ctl) begin
                nxt_rdata = {16'h0000, ctl_ff};
            end else if (hit_line) begin
                nxt_rdata = {16'h0000, line_word};
            end else if (hit_self) begin
                nxt_rdata = {16'h0000, self_word};
            end else begin
                nxt_rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_avs_readdata = rdata_ff;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    AST_LINE_ID: assert property (
        (accept && i_avs_read && hit_line) |-> (o_avs_readdata[5:0] == 6'h14)
    ) else $error("line status identifier wrong");
    AST_CTL_ID: assert property (
        (accept && i_avs_read && hit_ctl) |-> (o_avs_readdata[6:0] == 7'h15)
    ) else $error("self control identifier or reset bit wrong");
    AST_SELF_ID: assert property (
        (accept && i_avs_read && hit_self) |-> (o_avs_readdata[5:0] == 6'h16)
    ) else $error("self status identifier wrong");
    AST_RESET_ONCE: assert property (
        (wr_ctl && i_avs_byteenable[0] && i_avs_writedata[CTL_RESET])
            |=> o_chip_reset ##1 (!o_chip_reset && ctl_ff == 16'h0015)
    ) else $error("chip reset not a single pulse");
    // Only a write that really enters suspend owes a partial reset pulse
    AST_SUSPEND_ENTER: assert property (
        (wr_ctl && !nxt_chip_rst && !ctl_ff[CTL_SUSPEND] && i_avs_byteenable[1]
            && i_avs_writedata[CTL_SUSPEND]) |=> ##1 (o_partial_reset && o_txrx_halt)
    ) else $error("suspend not entered");
    // The sleep pin may still hold a hardware mode after the wake, so check suspend only
    AST_SUSPEND_EXIT: assert property (
        (ctl_ff[CTL_SUSPEND] && i_io_write_in_range && !wr_ctl && !i_mem.load_valid)
            |=> !ctl_ff[CTL_SUSPEND] ##1 (pwr_ff != PWR_SW_SUSPEND)
    ) else $error("suspend not left after I/O write");
    AST_HW_MODE: assert property (
        (!ctl_ff[CTL_SUSPEND] && ctl_ff[CTL_SLEEP_EN] && !pin_s.sleep && !chip_rst_ff)
            |=> (o_hw_standby == $past(ctl_ff[CTL_STANDBY]) && o_hw_suspend != o_hw_standby)
    ) else $error("hardware low-power mode wrong");
    AST_SLEEP_IGNORED: assert property (
        (!ctl_ff[CTL_SLEEP_EN] && !ctl_ff[CTL_SUSPEND] && !chip_rst_ff) |=> !o_txrx_halt
    ) else $error("sleep pin not ignored");
    AST_GEN_OUT0: assert property (
        (ctl_ff[CTL_SEL0]) |=> (o_general_output_0 == !$past(ctl_ff[CTL_VAL0]))
    ) else $error("general output 0 wrong level");
    AST_GEN_OUT1: assert property (
        (!ctl_ff[CTL_SEL1]) |=> (o_general_output_1 == !$past(i_rx_bus_activity))
    ) else $error("general output 1 not showing bus activity");
    AST_RO_WRITE: assert property (
        (accept && i_avs_write && (hit_line || hit_self) && !i_mem.load_valid
            && !i_io_write_in_range) |=> $stable(ctl_ff)
    ) else $error("read-only write changed state");
    AST_LINK_RESET: assert property (
        @(posedge i_clk) (!nrst_core) |=> !link_good
    ) else $error("link good not cleared by reset");
    COV_SUSPEND: cover property (o_partial_reset);
    COV_STANDBY: cover property (o_hw_standby);
    COV_CHIP_RESET: cover property (o_chip_reset);
    COV_LINE_READ: cover property (accept && i_avs_read && hit_line && o_avs_readdata[LS_CRS]);
endmodule

// ==== dv/lsc_host_model.sv ====
`timescale 1ns/1ps
module lsc_host_model (
    // Clock
    input wire logic i_clk,
    // Slave answer
    input wire logic i_waitrequest,
    input wire logic [31:0] i_readdata,
    // Requests
    output logic [11:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable
);
    initial begin
        o_address = 12'h000;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0000_0000;
        o_byteenable = 4'h0;
    end

    // Held until waitrequest is seen low at a rising edge; only then released
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] be);
        @(posedge i_clk);
        o_address <= a;
        o_writedata <= {16'h0000, d};
        o_byteenable <= be;
        o_write <= 1'b1;
        @(posedge i_clk);
        while (i_waitrequest) @(posedge i_clk);
        o_write <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_address <= a;
        o_byteenable <= 4'h3;
        o_read <= 1'b1;
        @(posedge i_clk);
        while (i_waitrequest) @(posedge i_clk);
        d = i_readdata[15:0];
        o_read <= 1'b0;
    endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import lsc_pkg::*;
    localparam logic [11:0] A_CTL = {IDX_SELF_CTL, 2'h0};
    localparam logic [11:0] A_LINE = {IDX_LINE_ST, 2'h0};
    localparam logic [11:0] A_ST = {IDX_SELF_ST, 2'h0};
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [11:0] adr;
    logic rd_s, wr_s, wait_s;
    logic [31:0] wdat, rdat;
    logic [3:0] be;
    lsc_pins_type pins = 7'h2F;
    lsc_mem_status_type mem = '0;
    logic pol_dis = 1'b0, tp_use = 1'b0, bus_act = 1'b0, io_wr = 1'b0;
    logic gen0, gen1, rx_inv, c_rst, p_rst, halt, standby, hsusp, seen;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;

    initial forever #12.5 i_clk = ~i_clk;

    lsc_host_model host (.i_clk(i_clk), .i_waitrequest(wait_s), .i_readdata(rdat),
        .o_address(adr), .o_read(rd_s), .o_write(wr_s), .o_writedata(wdat),
        .o_byteenable(be));

    // Short link timeout keeps the idle-link case within a few dozen cycles
    lsc_status_regs #(.LINK_FAIL_CYCLES(20)) dut (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdat),
        .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_s),
        .i_pins(pins), .i_polarity_fix_disable(pol_dis), .i_tp_in_use(tp_use),
        .i_rx_bus_activity(bus_act), .i_io_write_in_range(io_wr), .i_mem(mem),
        .o_rx_invert(rx_inv), .o_general_output_0(gen0), .o_general_output_1(gen1),
        .o_chip_reset(c_rst), .o_partial_reset(p_rst), .o_txrx_halt(halt),
        .o_hw_standby(standby), .o_hw_suspend(hsusp));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] d;
        host.rd(a, d);
        chk(d & m, e);
    endtask

    // A one-cycle pulse is seen at exactly one edge within the window
    task automatic catch_pulse(ref logic s, output logic hit);
        hit = 1'b0;
        repeat (6) begin
            @(posedge i_clk);
            hit = hit | s;
        end
    endtask

    task automatic t_reset();
        rdc(A_CTL, 16'hFFFF, 16'h0015);
        rdc(A_LINE, 16'h003F, 16'h0014);
        rdc(A_LINE, 16'h0080, 16'h0000);
        rdc(A_ST, 16'h003F, 16'h0016);
        rdc(A_ST, 16'h0200, 16'h0200);
        rdc(12'h000, 16'hFFFF, 16'h0000);
    endtask

    task automatic t_readonly();
        host.wr(A_LINE, 16'hFFFF, 4'h3);
        host.wr(A_ST, 16'hFFFF, 4'h3);
        rdc(A_LINE, 16'hFFFF, 16'h1114);
        rdc(A_ST, 16'hFFFF, 16'h0A56);
    endtask

    task automatic t_link();
        pins.tp_activity <= 1'b1;
        tick(8);
        rdc(A_LINE, 16'h0080, 16'h0080);
        chk(gen0, 1'b0);
        pins.tp_activity <= 1'b0;
        tick(30);
        rdc(A_LINE, 16'h0080, 16'h0000);
        chk(gen0, 1'b1);
    endtask

    task automatic t_carrier();
        fork
            repeat (16) begin
                @(posedge i_clk);
                pins.rx_data <= ~pins.rx_data;
            end
            begin
                tick(6);
                rdc(A_LINE, 16'h4000, 16'h4000);
            end
        join
        tick(20);
        rdc(A_LINE, 16'h4000, 16'h0000);
    endtask

    task automatic t_phy();
        for (int i = 0; i < 2; i++) begin
            @(posedge i_clk);
            tp_use <= i[0];
            pins.rx_polarity_ok <= i[0];
            tick(6);
            rdc(A_LINE, 16'h1300, {3'h0, i[0], 2'h0, i[0], ~i[0], 8'h00});
            chk(rx_inv, !i[0]);
        end
        pins.rx_polarity_ok <= 1'b0;
        pol_dis <= 1'b1;
        tick(6);
        chk(rx_inv, 1'b0);
        rdc(A_LINE, 16'h1000, 16'h0000);
        pins.rx_polarity_ok <= 1'b1;
        pol_dis <= 1'b0;
    endtask

    task automatic t_genout();
        mem.load_data <= 16'h3000;
        mem.load_valid <= 1'b1;
        @(posedge i_clk);
        mem.load_valid <= 1'b0;
        rdc(A_CTL, 16'hFFFF, 16'h3015);
        host.wr(A_CTL, 16'h7000, 4'h3);
        tick(2);
        chk({gen1, gen0}, 2'h2);
        host.wr(A_CTL, 16'hB000, 4'h3);
        tick(2);
        chk({gen1, gen0}, 2'h1);
        host.wr(A_CTL, 16'hC000, 4'h3);
        bus_act <= 1'b1;
        tick(3);
        chk({gen1, gen0}, 2'h1);
        bus_act <= 1'b0;
        tick(3);
        chk({gen1, gen0}, 2'h3);
        rdc(A_CTL, 16'hFFFF, 16'hC015);
    endtask

    task automatic t_sleep();
        host.wr(A_CTL, 16'h0600, 4'h3);
        pins.sleep <= 1'b0;
        tick(6);
        chk({standby, hsusp}, 2'h2);
        host.wr(A_CTL, 16'h0200, 4'h3);
        tick(6);
        chk({standby, hsusp}, 2'h1);
        host.wr(A_CTL, 16'h0000, 4'h3);
        tick(6);
        chk({standby, hsusp}, 2'h0);
        pins.sleep <= 1'b1;
    endtask

    task automatic t_suspend();
        host.wr(A_CTL, 16'h0100, 4'h3);
        catch_pulse(p_rst, seen);
        chk(seen, 1'b1);
        chk(halt, 1'b1);
        rdc(A_CTL, 16'hFFFF, 16'h0115);
        @(posedge i_clk);
        io_wr <= 1'b1;
        @(posedge i_clk);
        io_wr <= 1'b0;
        tick(3);
        chk(halt, 1'b0);
        rdc(A_CTL, 16'h0100, 16'h0000);
    endtask

    task automatic t_status();
        mem.init_done <= 1'b1;
        mem.mem_select <= 1'b1;
        mem.checksum_ok <= 1'b1;
        mem.size64 <= 1'b1;
        tick(4);
        rdc(A_ST, 16'hFFFF, 16'h1FD6);
        mem.checksum_ok <= 1'b0;
        mem.mem_select <= 1'b0;
        pins.ext_decode <= 1'b0;
        tick(4);
        rdc(A_ST, 16'hFFFF, 16'h02D6);
    endtask

    task automatic t_chip_reset();
        host.wr(A_CTL, 16'h3600, 4'h3);
        host.wr(A_CTL, 16'h0040, 4'h1);
        catch_pulse(c_rst, seen);
        chk(seen, 1'b1);
        rdc(A_CTL, 16'hFFFF, 16'h0015);
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        tick(20);
        i_nrst <= 1'b1;
        tick(4);
        t_reset();
        t_readonly();
        t_link();
        t_carrier();
        t_phy();
        t_genout();
        t_sleep();
        t_suspend();
        t_status();
        t_chip_reset();
        end_sim();
    end
endmodule
